// ===== logic/drs_pkg.sv
// constants and types shared by the result status word builder
package drs_pkg;
  localparam int          CLK_MHZ     = 125;      // system clock rate
  localparam int          TIMEOUT_US  = 1000000;  // transfer clock loss
  localparam int          TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  // result status field bit positions
  localparam int          B_DONE     = 0;   // operation complete
  localparam int          B_EXC      = 1;   // exception
  localparam int          B_ATTN     = 4;   // attention
  localparam int          B_UID      = 7;   // unit id, bits 7..9
  localparam int          B_APE      = 9;   // address parity / sync
  localparam int          B_SAE      = 10;  // sector address error
  localparam int          B_TMO      = 11;  // timeout
  localparam int          B_CFG      = 10;  // configuration, bits 10..11
  localparam int          B_SEEKING  = 12;  // seeking
  localparam int          B_SSFF     = 14;  // seek status flag set
  localparam int          B_XPAR     = 15;  // transmission parity
  localparam int          B_STORE    = 16;  // store bit, set unless suppressed; a parity error always sets it
  localparam int          B_CTYPE    = 17;  // control type, bits 17..23
  localparam int          B_FLAGS    = 21;  // special flags, bits 21..23
  localparam logic [2:0]  FLAG_EXT   = 3'h3;  // extended status held
  localparam logic [2:0]  FLAG_ECC   = 3'h1;  // correction read
  localparam logic [23:0] EXC_MASK   = 24'h00de00 | 24'h000200;
  // register map, byte addresses
  localparam logic [3:0]  A_CONFIG   = 4'h0;  // exchange code, rw
  localparam logic [3:0]  A_RESULT   = 4'h4;  // last result word, ro
  localparam logic [3:0]  A_STATUS   = 4'h8;  // busy / last end, ro
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
  localparam logic [1:0]  CONFIG_RST = 2'h0;  // direct connection
  // operation codes presented on the op port
  typedef enum logic [2:0] {
    OP_TEST  = 3'h0,
    OP_READ  = 3'h1,
    OP_WRITE = 3'h2,
    OP_INIT  = 3'h3,
    OP_RELOC = 3'h4
  } drs_op_type;
  // sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_RUN  = 2'h2
  } drs_state_type;
endpackage : drs_pkg

// ===== logic/drs_builder.sv
// result status word builder with an axi4-lite register slave
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module drs_builder #(
  parameter int unsigned TIMEOUT_CYCLES = drs_pkg::TIMEOUT_CYC,
  parameter logic [6:0]  CTRL_ID        = 7'h2a  // arbitrary value
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  // operation start and unit state
  input  wire logic        OP_START,       // one-cycle start
  input  wire logic [2:0]  OP_CODE,        // drs_op_type code
  input  wire logic        OP_ECC,         // read with correction
  input  wire logic        FAMILY_TWO,     // 0 first family, 1 second
  input  wire logic        UNIT_PRESENT,
  input  wire logic [2:0]  UNIT_GEOM,      // geometry code 001..110
  input  wire logic        UNIT_SEEKING,
  input  wire logic        SEEK_FLAG,      // seek status flag
  input  wire logic        ADDR_FIELD_OK,  // good-parity address field
  input  wire logic        CYL_MISMATCH,   // wrong cylinder requested
  // drive electronics controller events, one-cycle pulses, plus transfer lines and the status level
  input  wire logic        INITIATE_DONE,
  input  wire logic        SECTOR_FOUND,
  input  wire logic        SECTOR_MISSING,
  input  wire logic        ADDR_PAR_ERR,
  input  wire logic        DATA_SYNC_ERR,
  input  wire logic        NO_SECTOR_PULSE,
  input  wire logic        NO_READ_DATA,
  input  wire logic        READ_OVERRUN,
  input  wire logic        SEEK_TIMEOUT,
  input  wire logic        DECODE_FAIL,
  input  wire logic        ADDR_SYNC_FAIL,
  input  wire logic        XFER_CLK,
  input  wire logic [15:0] XFER_DATA,
  input  wire logic        XFER_PARITY,
  input  wire logic        EXT_STATUS,     // level
  input  wire logic        OP_END,
  // result to the host side
  output logic [23:0]      RESULT,
  output logic             RESULT_VALID,
  output logic             TERMINATE,
  output logic             SEEK_START,
  // axi4-lite slave
  input  wire logic [3:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [3:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY
);
  import drs_pkg::*;

  // multi-bit codes sit msb first at the lowest bit number of their field
  localparam logic [6:0] CTYPE_FIELD = {CTRL_ID[0], CTRL_ID[1], CTRL_ID[2],
                                        CTRL_ID[3], CTRL_ID[4], CTRL_ID[5],
                                        CTRL_ID[6]};
  localparam logic [2:0] EXT_FIELD   = {FLAG_EXT[0], FLAG_EXT[1],
                                        FLAG_EXT[2]};
  localparam logic [2:0] ECC_FIELD   = {FLAG_ECC[0], FLAG_ECC[1],
                                        FLAG_ECC[2]};

  // whole module state in one record
  typedef struct packed {
    drs_state_type state;       // sequencer
    drs_op_type    op;          // operation under way
    logic          ecc;         // correction read variant
    logic          fam2;        // second drive family
    logic [23:0]   acc;         // error bits gathered so far
    logic          found;       // starting sector seen
    logic          ape_wait;    // parity error before start sector
    logic          init_ph;     // still in initiate phase
    logic [31:0]   timer;       // cycles since last transfer clock
    logic [23:0]   result;      // last result word
    logic          valid;
    logic          term;
    logic          seek;
    logic          last_term;   // last operation was terminated
    logic [1:0]    exch;        // exchange configuration
    logic          aw_got;
    logic [3:0]    aw_addr;
    logic          w_got;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
  } drs_regs_type;

  drs_regs_type q;       // registered state
  drs_regs_type next_q;  // next state

  // final word: completion, exception and the store bit
  function automatic logic [23:0] finish(input logic [23:0] w,
                                         input logic        nostore);
    logic [23:0] r;
    r = w;
    r[B_DONE]  = 1'b1;
    r[B_EXC]   = |(w & EXC_MASK);
    r[B_STORE] = ~nostore | w[B_XPAR];
    return r;
  endfunction : finish

  logic        par_err;   // even parity on a transfer
  logic        rwr;       // read, write or relocate
  logic [23:0] w;         // working word
  logic        end_now;   // operation ends this cycle
  logic        kill;      // ended by a fault
  logic        nostore;   // suppress the store bit

  // sequencer, result assembly and register slave
  always_comb begin
    next_q  = q;
    next_q.valid = 1'b0;
    next_q.term  = 1'b0;
    next_q.seek  = 1'b0;
    par_err = XFER_CLK & ~^{XFER_DATA, XFER_PARITY};
    rwr     = (q.op == OP_READ) | (q.op == OP_WRITE) |
              (q.op == OP_RELOC);
    w       = q.acc;
    end_now = 1'b0;
    kill    = 1'b0;
    nostore = 1'b0;
    case (q.state)
      ST_IDLE: begin
        if (OP_START) begin
          next_q.op   = drs_op_type'(OP_CODE);
          next_q.ecc  = OP_ECC;
          next_q.fam2 = FAMILY_TWO;
          next_q.acc  = '0;
          next_q.found    = 1'b0;
          next_q.ape_wait = 1'b0;
          next_q.init_ph  = 1'b1;
          next_q.timer    = '0;
          next_q.state    = ST_RUN;
          w   = '0;
          rwr = (OP_CODE == OP_READ) | (OP_CODE == OP_WRITE) |
                (OP_CODE == OP_RELOC);
          if (OP_CODE == OP_TEST) begin
            // test answers at once from the unit state
            w[B_UID+2:B_UID] = UNIT_PRESENT ?
                               {UNIT_GEOM[0], UNIT_GEOM[1], UNIT_GEOM[2]} :
                               3'h0;
            w[B_CFG+1:B_CFG] = {q.exch[0], q.exch[1]};
            w[B_SEEKING]     = UNIT_SEEKING;
            w[B_SSFF]        = ~UNIT_SEEKING & SEEK_FLAG;
            w[23:B_CTYPE]    = CTYPE_FIELD;
            end_now = 1'b1;
          end else if (rwr & UNIT_SEEKING) begin
            w[B_SEEKING] = 1'b1;
            nostore = 1'b1;
            end_now = 1'b1;
          end else if (rwr & CYL_MISMATCH & SEEK_FLAG) begin
            w[B_SSFF] = 1'b1;
            nostore = 1'b1;
            end_now = 1'b1;
          end else if (rwr & CYL_MISMATCH & ADDR_FIELD_OK) begin
            w[B_SEEKING] = 1'b1;
            next_q.seek  = 1'b1;
            nostore = 1'b1;
            end_now = 1'b1;
          end else if (SEEK_TIMEOUT) begin
            w[B_TMO] = 1'b1;
            kill = 1'b1;
          end
        end
      end
      ST_RUN: begin
        // fault checks; some end the operation at once, others only set error bits
        if (XFER_CLK | ~rwr)
          next_q.timer = '0;
        else
          next_q.timer = q.timer + 32'h1;
        if (INITIATE_DONE)
          next_q.init_ph = 1'b0;
        if (SECTOR_FOUND)
          next_q.found = 1'b1;
        if (par_err) begin
          w[B_XPAR] = 1'b1;
          if (q.init_ph)
            kill = 1'b1;
        end
        if (ADDR_PAR_ERR) begin
          if (q.found)
            begin w[B_APE] = 1'b1; kill = 1'b1; end
          else
            next_q.ape_wait = 1'b1;
        end
        if (SECTOR_MISSING) begin
          if (q.ape_wait | ADDR_PAR_ERR | q.fam2)
            begin w[B_APE] = 1'b1; kill = 1'b1; end
          else if (rwr)
            begin w[B_SAE] = 1'b1; kill = 1'b1; end
        end
        if (DATA_SYNC_ERR & (q.op == OP_READ))
          begin w[B_APE] = 1'b1; kill = 1'b1; end
        if (NO_SECTOR_PULSE & ~q.fam2) begin
          w[B_ATTN] = 1'b1;
          w[B_APE]  = 1'b1;
          w[B_SAE]  = 1'b1;
          w[B_TMO]  = 1'b1;
          w[22]     = 1'b1;
          w[23]     = 1'b1;
          kill      = 1'b1;
        end
        if (NO_READ_DATA & ~q.fam2) begin
          w[B_APE] = 1'b1;
          w[B_SAE] = 1'b1;
          w[B_TMO] = 1'b1;
        end
        if (READ_OVERRUN & ~q.fam2)
          w[B_SAE] = 1'b1;
        if (~q.fam2 & (DECODE_FAIL | ADDR_SYNC_FAIL))
          w[B_TMO] = 1'b1;
        if (SEEK_TIMEOUT & (rwr | q.op == OP_INIT))
          begin w[B_TMO] = 1'b1; kill = 1'b1; end
        if (rwr & (q.timer >= TIMEOUT_CYCLES - 1))
          begin w[B_TMO] = 1'b1; kill = 1'b1; end
        if (OP_END)
          end_now = 1'b1;
        // flags on any end from the run state; extended status wins
        if (EXT_STATUS)
          begin w[23:B_FLAGS] = EXT_FIELD; nostore = 1'b1; end
        else if ((q.op == OP_READ) & q.ecc)
          begin w[23:B_FLAGS] = ECC_FIELD; nostore = 1'b1; end
        next_q.acc = w;
      end
      default: begin
        next_q.state = ST_IDLE;  // unreachable codes recover
      end
    endcase
    if (end_now | kill) begin
      next_q.result    = finish(w, nostore);
      next_q.valid     = 1'b1;
      next_q.term      = kill;
      next_q.last_term = kill;
      next_q.state     = ST_IDLE;
    end
    // write channel: address and data taken in either order
    if (AWVALID & q.awready)
      begin next_q.aw_got = 1'b1; next_q.aw_addr = AWADDR; end
    if (WVALID & q.wready) begin
      next_q.w_got  = 1'b1;
      next_q.w_data = WDATA;
      next_q.w_strb = WSTRB;
    end
    if (q.aw_got & q.w_got & ~q.bvalid) begin
      next_q.aw_got = 1'b0;
      next_q.w_got  = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp  = RESP_SLV;
      if (q.aw_addr == A_CONFIG) begin
        next_q.bresp = RESP_OKAY;
        if (q.w_strb[0])
          next_q.exch = q.w_data[1:0];  // steers the test answer
      end
    end
    if (q.bvalid & BREADY)
      next_q.bvalid = 1'b0;
    next_q.awready = ~next_q.aw_got & ~next_q.bvalid;
    next_q.wready  = ~next_q.w_got & ~next_q.bvalid;
    // read channel
    if (ARVALID & q.arready) begin
      next_q.rvalid = 1'b1;
      next_q.rresp  = RESP_OKAY;
      case (ARADDR)
        A_CONFIG: next_q.rdata = {30'h0, q.exch};
        A_RESULT: next_q.rdata = {8'h0, q.result};
        A_STATUS: next_q.rdata = {30'h0, q.last_term,
                                  q.state == ST_RUN};
        default: begin
          next_q.rdata = '0;
          next_q.rresp = RESP_SLV;  // unmapped address
        end
      endcase
    end else if (q.rvalid & RREADY) begin
      next_q.rvalid = 1'b0;
    end
    next_q.arready = ~next_q.rvalid;
  end

  // one register bank for the whole state
  always_ff @(posedge CLK) begin
    if (RESET) begin
      q         <= '0;
      q.state   <= ST_IDLE;
      q.op      <= OP_TEST;
      q.exch    <= CONFIG_RST;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign RESULT       = q.result;
  assign RESULT_VALID = q.valid;
  assign TERMINATE    = q.term;
  assign SEEK_START   = q.seek;
  assign AWREADY      = q.awready;
  assign WREADY       = q.wready;
  assign BVALID       = q.bvalid;
  assign BRESP        = q.bresp;
  assign ARREADY      = q.arready;
  assign RVALID       = q.rvalid;
  assign RDATA        = q.rdata;
  assign RRESP        = q.rresp;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  // test answers on the next edge with geometry and type
  property p_test_geom;
    (q.state == ST_IDLE) & OP_START & (OP_CODE == OP_TEST) & UNIT_PRESENT
    |=> RESULT_VALID &&
        {RESULT[7], RESULT[8], RESULT[9]} == $past(UNIT_GEOM);
  endproperty
  a_test_geom: assert property (p_test_geom) else $error("bad unit id");
  property p_test_type;
    (q.state == ST_IDLE) & OP_START & (OP_CODE == OP_TEST)
    |=> RESULT[23:17] == CTYPE_FIELD &&
        {RESULT[10], RESULT[11]} == $past(q.exch);
  endproperty
  a_test_type: assert property (p_test_type) else $error("bad type");
  property p_seeking;
    (q.state == ST_IDLE) & OP_START & UNIT_SEEKING &
    (OP_CODE == OP_READ)
    |=> RESULT_VALID && RESULT[12] && !RESULT[16] && !SEEK_START;
  endproperty
  a_seeking: assert property (p_seeking) else $error("seeking");
  property p_seek_start;
    SEEK_START |-> RESULT_VALID && RESULT[12] && !RESULT[14];
  endproperty
  a_seek_start: assert property (p_seek_start) else $error("seek");
  property p_par_store;
    RESULT_VALID && RESULT[15] |-> RESULT[16];
  endproperty
  a_par_store: assert property (p_par_store) else $error("par store");
  property p_flags;
    RESULT_VALID && $past(q.state) == ST_RUN && $past(EXT_STATUS) &&
    !RESULT[15]
    |-> RESULT[23:21] == EXT_FIELD && !RESULT[16];
  endproperty
  a_flags: assert property (p_flags) else $error("ext flags");
  property p_done;
    RESULT_VALID |-> RESULT[0] && (TERMINATE || !$past(TERMINATE));
  endproperty
  a_done: assert property (p_done) else $error("no complete");
  property p_exc;
    RESULT_VALID |-> RESULT[1] == |(RESULT & EXC_MASK);
  endproperty
  a_exc: assert property (p_exc) else $error("exception bit");
  property p_tmo;
    (q.state == ST_RUN) & SEEK_TIMEOUT & (q.op != OP_TEST)
    |=> TERMINATE && RESULT[11];
  endproperty
  a_tmo: assert property (p_tmo) else $error("seek timeout");
  property p_bhold;
    BVALID & !BREADY |=> BVALID && $stable(BRESP);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");

  c_test: cover property (RESULT_VALID && RESULT[23:17] == CTYPE_FIELD);
  c_seek: cover property (SEEK_START);
  c_term: cover property (TERMINATE ##1 (q.state == ST_IDLE));
  c_wr:   cover property (BVALID && BREADY && BRESP == RESP_OKAY);
endmodule : drs_builder

// ===== verif/drs_dec_model.sv
// far-side controller model: event pulses, transfers and status level
`timescale 1ns/100ps
module drs_dec_model (
  input  wire logic        clk,   // system clock
  output logic [11:0]      ev,    // one-cycle event pulses
  output logic             xclk,  // transfer strobe
  output logic [15:0]      xdata, // transfer word
  output logic             xpar,  // parity bit of the word
  output logic             ext    // extended status held
);
  logic [11:0] evq;   // pulse pattern for the next rising edge
  logic        go;    // transfer wanted at the next rising edge
  logic        bad;   // send the wrong parity sense on purpose
  logic [15:0] wd;    // word to send
  logic        extq;  // wanted status level
  initial begin
    ev = '0;
    xclk = 1'b0;
    xdata = 16'h0;
    xpar = 1'b0;
    ext = 1'b0;
    evq = '0;
    go = 1'b0;
    bad = 1'b0;
    wd = 16'h0;
    extq = 1'b0;
  end
  // requests are staged on the falling edge, so they are settled here
  always @(posedge clk) begin
    ev    <= evq;
    xclk  <= go;
    ext   <= extq;
    // idle lines keep moving, so a stale word never looks held
    xdata <= go ? wd : ~xdata;
    xpar  <= go ? (~^wd ^ bad) : ~xpar;
  end
  // one pulse on event line i; an index past the lines sends nothing
  task automatic fire(input int i);
    @(negedge clk);
    evq = 12'(1 << i);
    @(negedge clk);
    evq = '0;
  endtask : fire
  // one transfer, odd parity unless told to break it
  task automatic xfer(input logic [15:0] d, input logic b);
    @(negedge clk);
    wd = d;
    bad = b;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
  endtask : xfer
  task automatic setx(input logic v);
    @(negedge clk);
    extq = v;
  endtask : setx
endmodule : drs_dec_model

// ===== verif/drs_builder_tb_top.sv
// self-checking bench for the result status word builder
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module drs_builder_tb_top;
  import drs_pkg::*;
  localparam logic [6:0] CID = 7'h55;  // arbitrary value
  localparam int         TMO = 16;     // short clock-loss limit
  localparam logic [9:0] U   = 10'h242; // present, geometry 1, field ok
  localparam logic [2:0] GEO [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
  logic        CLK, RESET, OP_START, OP_ECC, FAMILY_TWO, UNIT_PRESENT;
  logic        UNIT_SEEKING, SEEK_FLAG, ADDR_FIELD_OK, CYL_MISMATCH;
  logic [2:0]  OP_CODE, UNIT_GEOM;
  logic [11:0] ev;         // controller event pulses
  logic        XFER_CLK, XFER_PARITY, EXT_STATUS;
  logic [15:0] XFER_DATA;
  logic [23:0] RESULT, rw; // live and captured result word
  logic        RESULT_VALID, TERMINATE, SEEK_START, rt, rs;
  logic [3:0]  AWADDR, ARADDR, WSTRB;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY;
  logic [31:0] WDATA, RDATA;
  logic [1:0]  BRESP, RRESP;
  int          fails = 0, compares = 0, cyc = 0, rn = 0, n0 = 0;
  drs_builder #(.TIMEOUT_CYCLES(TMO), .CTRL_ID(CID)) dut_u (
    .CLK, .RESET, .OP_START, .OP_CODE, .OP_ECC, .FAMILY_TWO, .UNIT_PRESENT,
    .UNIT_GEOM, .UNIT_SEEKING, .SEEK_FLAG, .ADDR_FIELD_OK, .CYL_MISMATCH,
    .INITIATE_DONE(ev[0]), .SECTOR_FOUND(ev[1]), .SECTOR_MISSING(ev[2]),
    .ADDR_PAR_ERR(ev[3]), .DATA_SYNC_ERR(ev[4]), .NO_SECTOR_PULSE(ev[5]),
    .NO_READ_DATA(ev[6]), .READ_OVERRUN(ev[7]), .SEEK_TIMEOUT(ev[8]),
    .DECODE_FAIL(ev[9]), .ADDR_SYNC_FAIL(ev[10]), .OP_END(ev[11]),
    .XFER_CLK, .XFER_DATA, .XFER_PARITY, .EXT_STATUS, .RESULT,
    .RESULT_VALID, .TERMINATE, .SEEK_START, .AWADDR, .AWVALID, .AWREADY,
    .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
    .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
  drs_dec_model m_u (.clk(CLK), .ev(ev), .xclk(XFER_CLK), .xdata(XFER_DATA),
    .xpar(XFER_PARITY), .ext(EXT_STATUS));
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  // capture each announced word; the cycle ceiling cuts a hang short
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (RESULT_VALID === 1'b1) begin
      rw <= RESULT;
      rt <= TERMINATE;
      rs <= SEEK_START;
      rn <= rn + 1;
    end
    if (cyc == 4000) begin
      fails++;
      test_done();
    end
  end
  // code v placed with its first bit at position p, msb first
  function automatic logic [23:0] fld(int p, int n, logic [6:0] v);
    fld = '0;
    for (int i = 0; i < n; i++) fld[p + i] = v[n - 1 - i];
  endfunction : fld
  // completion, store and exception bits added to the error bits
  function automatic logic [23:0] fin(logic [23:0] w, logic ns);
    fin = w | 24'h000001;
    if (!ns || w[15]) fin[16] = 1'b1;
    fin[1] = |(fin & 24'h00de00);
  endfunction : fin
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge CLK);
    AWADDR  <= a;
    WDATA   <= d;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    do begin
      @(posedge CLK);
      if (AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WREADY === 1'b1) WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    r = BRESP;
    BREADY <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge CLK);
    ARADDR  <= a;
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    do begin
      @(posedge CLK);
      if (ARREADY === 1'b1) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
  endtask : rd
  // lv: present, geometry, ecc, family, seeking, flag, field ok, mismatch
  task automatic start(input logic [2:0] c, input logic [9:0] lv);
    n0 = rn;
    @(posedge CLK);
    OP_START <= 1'b1;
    OP_CODE  <= c;
    {UNIT_PRESENT, UNIT_GEOM, OP_ECC, FAMILY_TWO, UNIT_SEEKING, SEEK_FLAG,
     ADDR_FIELD_OK, CYL_MISMATCH} <= lv;
    @(posedge CLK);
    OP_START <= 1'b0;
  endtask : start
  // start, initiate done, two events, then the end of the operation
  task automatic run(input logic [2:0] c, input logic [9:0] lv,
                     input int p, input int e);
    start(c, lv);
    m_u.fire(0);
    m_u.fire(p);
    m_u.fire(e);
    m_u.fire(11);
  endtask : run
  // wait for the word; t of 2 leaves the terminate pulse unchecked
  task automatic look(input logic [23:0] e, input logic [23:0] m,
                      input logic [1:0] t, input logic s);
    int k;
    for (k = 0; k < 60 && rn == n0; k++) begin
      @(posedge CLK);
      #1;
    end
    `CHK(rn != n0, 1'b1)
    `CHK(rw & m, e & m)
    if (t != 2'h2) `CHK(rt, t[0])
    `CHK(rs, s)
  endtask : look
  task automatic flt(input int p, input int e, input logic f,
                     input logic [23:0] b, input logic [1:0] t);
    run(OP_READ, U | {5'h0, f, 4'h0}, p, e);
    look(fin(b, 1'b0), e == 5 ? 24'hfeffff : '1, t, 1'b0);
  endtask : flt
  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    RESET = 1'b1;
    {OP_START, OP_CODE, UNIT_GEOM, UNIT_PRESENT, OP_ECC, FAMILY_TWO} = '0;
    {UNIT_SEEKING, SEEK_FLAG, ADDR_FIELD_OK, CYL_MISMATCH} = '0;
    {AWADDR, ARADDR, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
    WDATA = 32'h0;
    WSTRB = 4'hf;
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    `CHK(RESULT, 24'h0)
    rd(A_CONFIG, d, r);
    `CHK({d, r}, {32'(CONFIG_RST), RESP_OKAY})
    $display("test reset done");
    // geometry codes 0, 1, 2, 5 and 6, every configuration code, seeking and flag combined
    for (int i = 0; i < 5; i++) begin
      wr(A_CONFIG, 32'(i[1:0]), r);
      `CHK(r, RESP_OKAY)
      run(OP_TEST, {i != 0, GEO[i], 2'h0, i[0], i[1], 2'h0}, 12, 12);
      look(fin(fld(7, 3, GEO[i]) | fld(10, 2, 7'(i[1:0])) | {i[0], 12'h0}
        | {~i[0] & i[1], 14'h0} | fld(17, 7, CID), 1'b0), 24'hfffffd,
        2'h0, 1'b0);
    end
    run(OP_TEST, 10'h0c0, 12, 12);
    look(fin(fld(17, 7, CID), 1'b0), 24'hfffffd, 2'h0, 1'b0);
    $display("test probe done");
    run(OP_READ, U | 10'h8, 12, 12);
    look(fin(24'h001000, 1'b1), '1, 2'h0, 1'b0);
    run(OP_WRITE, U | 10'h1, 12, 12);
    look(fin(24'h001000, 1'b1), '1, 2'h0, 1'b1);
    run(OP_RELOC, U | 10'h5, 12, 12);
    look(fin(24'h004000, 1'b1), '1, 2'h0, 1'b0);
    for (int c = 1; c < 5; c++) begin
      run(3'(c), U, 12, 12);
      look(fin(24'h0, 1'b0), '1, 2'h0, 1'b0);
    end
    $display("test start cases done");
    flt(1, 3, 1'b0, 24'h000200, 2'h1);
    flt(3, 2, 1'b0, 24'h000200, 2'h1);
    flt(3, 1, 1'b0, 24'h000000, 2'h0);
    flt(12, 4, 1'b0, 24'h000200, 2'h1);
    flt(12, 5, 1'b0, 24'hc00e10, 2'h1);
    flt(12, 6, 1'b0, 24'h000e00, 2'h0);
    flt(12, 2, 1'b1, 24'h000200, 2'h1);
    flt(12, 2, 1'b0, 24'h000400, 2'h1);
    flt(12, 7, 1'b0, 24'h000400, 2'h0);
    flt(12, 9, 1'b0, 24'h000800, 2'h0);
    flt(12, 10, 1'b0, 24'h000800, 2'h0);
    run(OP_INIT, U, 12, 8);
    look(fin(24'h000800, 1'b0), '1, 2'h1, 1'b0);
    rd(A_RESULT, d, r);
    `CHK(d, {8'h0, fin(24'h000800, 1'b0)})
    rd(A_STATUS, d, r);
    `CHK(d, 32'h2)
    $display("test faults done");
    // silence ends the run; spaced transfers keep it alive
    start(OP_WRITE, U);
    m_u.fire(0);
    look(fin(24'h000800, 1'b0), '1, 2'h1, 1'b0);
    start(OP_READ, U);
    m_u.fire(0);
    repeat (3) begin
      repeat (10) @(posedge CLK);
      m_u.xfer(16'h1234, 1'b0);
    end
    m_u.fire(11);
    look(fin(24'h0, 1'b0), '1, 2'h0, 1'b0);
    start(OP_WRITE, U);
    m_u.xfer(16'h0f0f, 1'b1);
    look(fin(24'h008000, 1'b1), '1, 2'h1, 1'b0);
    start(OP_RELOC, U);
    m_u.fire(0);
    m_u.xfer(16'h0f0f, 1'b1);
    m_u.fire(11);
    look(fin(24'h008000, 1'b0), '1, 2'h0, 1'b0);
    $display("test timing and parity done");
    run(OP_READ, U | 10'h20, 12, 12);
    look(fin(fld(21, 3, 7'h1), 1'b1), '1, 2'h0, 1'b0);
    m_u.setx(1'b1);
    run(OP_READ, U | 10'h20, 12, 12);
    look(fin(fld(21, 3, 7'h3), 1'b1), '1, 2'h2, 1'b0);
    run(OP_WRITE, U, 12, 12);
    look(fin(fld(21, 3, 7'h3), 1'b1), '1, 2'h2, 1'b0);
    m_u.setx(1'b0);
    wr(A_RESULT, 32'h0, r);
    `CHK(r, RESP_SLV)
    // a write with no byte lanes enabled must leave the exchange code alone
    WSTRB <= 4'h0;
    wr(A_CONFIG, 32'h3, r);
    `CHK(r, RESP_OKAY)
    WSTRB <= 4'hf;
    rd(A_CONFIG, d, r);
    `CHK({d, r}, {32'h0, RESP_OKAY})
    rd(4'hc, d, r);
    `CHK({d, r}, {32'h0, RESP_SLV})
    $display("test flags and registers done");
    test_done();
  end
endmodule : drs_builder_tb_top
